//--- rtl/cmp_ctrl_pkg.sv
// Package for the comparator control block: register map, field layout, codes.
// Assumes a 32-bit AXI4-Lite master and one 25 MHz clock.
`default_nettype none
package cmp_ctrl_pkg;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL0 = 8'h00;
    localparam logic [7:0] OFF_CTRL1 = 8'h04;
    localparam logic [7:0] OFF_PSEL = 8'h08;
    localparam logic [7:0] OFF_NSEL = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;
    localparam logic [7:0] OFF_INT_CTRL0 = 8'h1c;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int B_ENABLE = 7;
    localparam int B_RESULT = 6;
    localparam int B_INVERT = 4;
    localparam int B_HYST = 1;
    localparam int B_ALIGN = 0;
    localparam int B_RISE_EN = 1;
    localparam int B_FALL_EN = 0;
    localparam int B_GIE = 7;
    localparam int B_FLAG = 0;
    localparam int SEL_W = 3;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Positive source codes
    typedef enum logic [2:0] {
        PSRC_PIN0 = 3'b000,
        PSRC_PIN1 = 3'b001,
        PSRC_DAC = 3'b010,
        PSRC_FVR = 3'b011,
        PSRC_GND = 3'b100
    } psrc_t;

    // Negative source codes
    typedef enum logic [2:0] {
        NSRC_PIN0 = 3'b000,
        NSRC_PIN1 = 3'b001,
        NSRC_PIN2 = 3'b010,
        NSRC_PIN3 = 3'b011,
        NSRC_FVR = 3'b100,
        NSRC_GND = 3'b101
    } nsrc_t;

    // Analog switch controls, one-hot per source
    typedef struct packed {
        logic [4:0] pos_route;
        logic [5:0] neg_route;
        logic hyst_on;
    } analog_ctl_t;
endpackage
`default_nettype wire

//--- rtl/cmp_ctrl.sv
// Comparator digital control: AXI4-Lite registers, source routing, hysteresis,
// optional timer alignment, edge detection and interrupt flag logic.
// Assumes the analog comparator output and timer clock level are synchronous.
//
// Contract
// - Hysteresis switched in only while hysteresis_enable is set.
// - With alignment, result captured on timer clock falling edge; else passes.
// - Aligned result updates in step with timer, never transitional.
// - Separate rising and falling edge detectors on the result.
// - Flag sets on rising with rise enable or falling with fall enable.
// - Flag never cleared by hardware, only by software write.
// - Edge during a software clear wins; flag stays set.
// - Invert or enable toggles may change result and raise edges.
// - Positive select routes pin0, pin1, converter, reference or ground.
// - Negative select routes four pins, reference or analog ground.
// - Comparator disabled disconnects every input regardless of selects.
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`default_nettype none
module cmp_ctrl
    import cmp_ctrl_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CMP_RAW,
    input wire logic TIMER_CLK,
    output logic [4:0] POS_ROUTE,
    output logic [5:0] NEG_ROUTE,
    output logic HYST_ON,
    output logic IRQ,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] ctrl0, next_ctrl0;
    logic [7:0] ctrl1, next_ctrl1;
    logic [2:0] psel, next_psel;
    logic [2:0] nsel, next_nsel;
    logic irq_flag, next_irq_flag;
    logic irq_en, next_irq_en;
    logic global_irq_enable, next_gie;
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [1:0] rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic tclk_q, aligned, final_q, next_aligned, next_final_q;
    analog_ctl_t actl, next_actl;
    logic irq_out, next_irq_out;
    logic result, rise, fall, do_write, clr_flag;
    // Register index decode used by both channels
    function automatic logic is_off(input logic [7:0] a, input logic [7:0] off);
        is_off = (a[7:2] == off[7:2]);
    endfunction
    // ----------------------------------------------------------------
    // Result path
    // ----------------------------------------------------------------
    // Capture on timer clock fall so the visible bit changes only with the timer
    always_comb
    begin
        next_aligned = aligned;
        if (tclk_q && !TIMER_CLK)
            next_aligned = CMP_RAW;
    end

    // Disabled comparator reads low before inversion, so toggles still move it
    always_comb
    begin
        logic pre;
        pre = ctrl0[B_ALIGN] ? aligned : CMP_RAW;
        if (!ctrl0[B_ENABLE])
            pre = 1'b0;
        result = pre ^ ctrl0[B_INVERT];
        next_final_q = result;
        rise = result && !final_q;
        fall = !result && final_q;
    end

    // Analog switch controls
    always_comb
    begin
        next_actl = '0;
        next_actl.hyst_on = ctrl0[B_HYST];
        if (ctrl0[B_ENABLE])
        begin
            unique case (psel)
                PSRC_PIN0: next_actl.pos_route[0] = 1'b1;
                PSRC_PIN1: next_actl.pos_route[1] = 1'b1;
                PSRC_DAC: next_actl.pos_route[2] = 1'b1;
                PSRC_FVR: next_actl.pos_route[3] = 1'b1;
                PSRC_GND: next_actl.pos_route[4] = 1'b1;
                default: next_actl.pos_route = '0; // Unused codes connect nothing
            endcase
            unique case (nsel)
                NSRC_PIN0: next_actl.neg_route[0] = 1'b1;
                NSRC_PIN1: next_actl.neg_route[1] = 1'b1;
                NSRC_PIN2: next_actl.neg_route[2] = 1'b1;
                NSRC_PIN3: next_actl.neg_route[3] = 1'b1;
                NSRC_FVR: next_actl.neg_route[4] = 1'b1;
                NSRC_GND: next_actl.neg_route[5] = 1'b1;
                default: next_actl.neg_route = '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave and register writes
    // ----------------------------------------------------------------
    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_ctrl0 = ctrl0;
        next_ctrl1 = ctrl1;
        next_psel = psel;
        next_nsel = nsel;
        next_irq_en = irq_en;
        next_gie = global_irq_enable;
        clr_flag = 1'b0;
        if (S_AXI_AWVALID && !aw_held)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !w_held)
        begin
            next_w_held = 1'b1;
            next_w_data = S_AXI_WDATA;
            next_w_strb = S_AXI_WSTRB;
        end
        do_write = aw_held && w_held && !bvalid;
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            if (w_strb[0])
            begin
                if (is_off(aw_addr, OFF_CTRL0))
                    next_ctrl0 = w_data[7:0] & ~(8'h01 << B_RESULT);
                else if (is_off(aw_addr, OFF_CTRL1))
                    next_ctrl1 = w_data[7:0] & 8'h03;
                else if (is_off(aw_addr, OFF_PSEL))
                    next_psel = w_data[SEL_W-1:0];
                else if (is_off(aw_addr, OFF_NSEL))
                    next_nsel = w_data[SEL_W-1:0];
                else if (is_off(aw_addr, OFF_IRQ_CLEAR))
                    clr_flag = w_data[B_FLAG];
                else if (is_off(aw_addr, OFF_IRQ_ENABLE))
                    next_irq_en = w_data[B_FLAG];
                else if (is_off(aw_addr, OFF_INT_CTRL0))
                    next_gie = w_data[B_GIE];
                else if (!is_off(aw_addr, OFF_IRQ_STATUS))
                    next_bresp = RESP_SLVERR;
            end
        end
        if (bvalid && S_AXI_BREADY)
            next_bvalid = 1'b0;
    end
    // Read channel: one-cycle decode after the address is taken
    always_comb
    begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && S_AXI_RREADY)
            next_rvalid = 1'b0;
        if (S_AXI_ARVALID && !rvalid)
        begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = '0;
            if (is_off(S_AXI_ARADDR, OFF_CTRL0))
                next_rdata[7:0] = ctrl0 | (8'(final_q) << B_RESULT); // Visible result bit
            else if (is_off(S_AXI_ARADDR, OFF_CTRL1))
                next_rdata[7:0] = ctrl1;
            else if (is_off(S_AXI_ARADDR, OFF_PSEL))
                next_rdata[SEL_W-1:0] = psel;
            else if (is_off(S_AXI_ARADDR, OFF_NSEL))
                next_rdata[SEL_W-1:0] = nsel;
            else if (is_off(S_AXI_ARADDR, OFF_IRQ_STATUS))
                next_rdata[B_FLAG] = irq_flag;
            else if (is_off(S_AXI_ARADDR, OFF_IRQ_ENABLE))
                next_rdata[B_FLAG] = irq_en;
            else if (is_off(S_AXI_ARADDR, OFF_INT_CTRL0))
                next_rdata[B_GIE] = global_irq_enable;
            else if (!is_off(S_AXI_ARADDR, OFF_IRQ_CLEAR))
                next_rresp = RESP_SLVERR;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt flag
    // ----------------------------------------------------------------
    // Set beats clear so an edge during the clear is never lost
    always_comb
    begin
        logic set_ev;
        set_ev = (rise && ctrl1[B_RISE_EN]) || (fall && ctrl1[B_FALL_EN]);
        next_irq_flag = irq_flag;
        if (clr_flag)
            next_irq_flag = 1'b0;
        if (set_ev)
            next_irq_flag = 1'b1;
        next_irq_out = next_irq_flag && irq_en && global_irq_enable;
    end

    // State registers
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ctrl0 <= '0;
            ctrl1 <= '0;
            psel <= '0;
            nsel <= '0;
            irq_flag <= 1'b0;
            irq_en <= 1'b0;
            global_irq_enable <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= '0;
            tclk_q <= 1'b0;
            aligned <= 1'b0;
            final_q <= 1'b0;
            actl <= '0;
            irq_out <= 1'b0;
        end
        else
        begin
            ctrl0 <= next_ctrl0;
            ctrl1 <= next_ctrl1;
            psel <= next_psel;
            nsel <= next_nsel;
            irq_flag <= next_irq_flag;
            irq_en <= next_irq_en;
            global_irq_enable <= next_gie;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            tclk_q <= TIMER_CLK;
            aligned <= next_aligned;
            final_q <= next_final_q;
            actl <= next_actl;
            irq_out <= next_irq_out;
        end
    end

    // Outputs straight from flip-flops
    assign POS_ROUTE = actl.pos_route;
    assign NEG_ROUTE = actl.neg_route;
    assign HYST_ON = actl.hyst_on;
    assign IRQ = irq_out;
    assign S_AXI_AWREADY = !aw_held;
    assign S_AXI_WREADY = !w_held;
    assign S_AXI_BVALID = bvalid;
    assign S_AXI_BRESP = bresp;
    assign S_AXI_ARREADY = !rvalid;
    assign S_AXI_RVALID = rvalid;
    assign S_AXI_RDATA = rdata;
    assign S_AXI_RRESP = rresp;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence edge_rise_s;
        rise && ctrl1[B_RISE_EN];
    endsequence
    hyst_follow_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        1'b1 |=> HYST_ON == $past(ctrl0[B_HYST])) else $error("hysteresis mismatch");
    align_capture_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (tclk_q && !TIMER_CLK) |=> aligned == $past(CMP_RAW)) else $error("align miss");
    align_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !(tclk_q && !TIMER_CLK) |=> $stable(aligned)) else $error("aligned moved");
    edge_detect_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (result != final_q) |=> final_q != $past(final_q)) else $error("edge missed");
    rise_sets_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        edge_rise_s |=> irq_flag) else $error("rise not flagged");
    fall_sets_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (fall && ctrl1[B_FALL_EN]) |=> irq_flag) else $error("fall not flagged");
    flag_sticky_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (irq_flag && !clr_flag) |=> irq_flag) else $error("flag dropped");
    set_wins_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (clr_flag and edge_rise_s) |=> irq_flag) else $error("clear beat set");
    invert_toggle_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (!ctrl0[B_ENABLE] && !$past(ctrl0[B_ENABLE]) && $changed(ctrl0[B_INVERT]))
        |-> result != final_q)
        else $error("invert no edge");
    disabled_open_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !ctrl0[B_ENABLE] |=> POS_ROUTE == '0 && NEG_ROUTE == '0) else $error("input on");
    route_one_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (ctrl0[B_ENABLE] && psel == PSRC_FVR) |=> POS_ROUTE[3]) else $error("pos route");
    nroute_one_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (ctrl0[B_ENABLE] && nsel == NSRC_GND) |=> NEG_ROUTE[5]) else $error("neg route");
endmodule // cmp_ctrl
`default_nettype wire

//--- verification/analog_front_model.sv
// Behavioural analog side of the comparator: source levels, comparator, timer clock.
// Assumes the bench changes levels and timer run just after rising CLOCK edges.
`default_nettype none
module analog_front_model
    import cmp_ctrl_pkg::*;
#(
    parameter logic [7:0] HYST_MV = 8'h10,
    parameter int TMR_HALF = 3
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] pos_lvl [5],
    input wire logic [7:0] neg_lvl [6],
    input wire logic [4:0] pos_route,
    input wire logic [5:0] neg_route,
    input wire logic hyst_on,
    input wire logic tmr_run,
    output logic cmp_raw,
    output logic timer_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Source switching and comparison
    // ------------------------------------------------------------
    logic [8:0] pv;
    logic [8:0] nv;
    int cnt;

    // Pins act as analog inputs with drivers off; an open switch adds nothing
    always_comb
    begin
        pv = '0;
        nv = '0;
        for (int i = 0; i < 5; i++)
            if (pos_route[i])
                pv = pv + 9'(pos_lvl[i]);
        for (int i = 0; i < 6; i++)
            if (neg_route[i])
                nv = nv + 9'(neg_lvl[i]);
    end

    // Inside the hysteresis band the output keeps its last level
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n)
            cmp_raw <= 1'b0;
        else if (!hyst_on)
            cmp_raw <= (pv > nv);
        else if (pv > nv + 9'(HYST_MV))
            cmp_raw <= 1'b1;
        else if (pv + 9'(HYST_MV) < nv)
            cmp_raw <= 1'b0;

    // Timer source clock stands still while the timer is stopped
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n)
        begin
            cnt <= 0;
            timer_clk <= 1'b1;
        end
        else if (tmr_run)
        begin
            cnt <= (cnt == TMR_HALF - 1) ? 0 : cnt + 1;
            if (cnt == TMR_HALF - 1)
                timer_clk <= !timer_clk;
        end
endmodule // analog_front_model
`default_nettype wire

//--- verification/comparator_edge_irq_control_bench.sv
// Self-checking bench for the comparator control block over AXI4-Lite.
// Assumes the package register map and the analog model beside the design.
`default_nettype none
module comparator_edge_irq_control_bench
    import cmp_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals, clock and instances
    // ------------------------------------------------------------
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic tmr_run = 1'b0;
    logic [7:0] pos_lvl [5] = '{default: 8'h20};
    logic [7:0] neg_lvl [6] = '{default: 8'h80};
    logic cmp_raw, timer_clk, hyst_on, irq;
    logic [4:0] pos_route;
    logic [5:0] neg_route;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    int fail_count = 0, cmp_count = 0, seed = 53097;

    // Free-running 25 MHz system clock
    initial
        forever #20 clock = ~clock;

    cmp_ctrl cmp_ctrl_i (.CLOCK(clock), .RST_N(rst_n), .CMP_RAW(cmp_raw),
        .TIMER_CLK(timer_clk), .POS_ROUTE(pos_route), .NEG_ROUTE(neg_route),
        .HYST_ON(hyst_on), .IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    analog_front_model analog_front_model_i (.clock(clock), .rst_n(rst_n),
        .pos_lvl(pos_lvl), .neg_lvl(neg_lvl), .pos_route(pos_route),
        .neg_route(neg_route), .hyst_on(hyst_on), .tmr_run(tmr_run),
        .cmp_raw(cmp_raw), .timer_clk(timer_clk));

    // ------------------------------------------------------------
    // Checking, bus tasks and expectations
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa, pw, pb;
        int n;
        pa = 1'b1;
        pw = 1'b1;
        pb = 1'b1;
        n = 0;
        r = 2'b11;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pb && n < 100)
        begin
            @(posedge clock);
            n++;
            if (pa && awready)
                pa = 1'b0;
            if (pw && wready)
                pw = 1'b0;
            if (bvalid)
                r = bresp;
            pb = pb && !bvalid;
            awvalid <= pa;
            wvalid <= pw;
            bready <= pb;
        end
        if (n >= 100)
            check(32'(n), 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic pa, pr;
        int n;
        pa = 1'b1;
        pr = 1'b1;
        n = 0;
        d = 32'h0;
        r = 2'b11;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (pr && n < 100)
        begin
            @(posedge clock);
            n++;
            if (pa && arready)
                pa = 1'b0;
            if (rvalid)
                d = rdata;
            if (rvalid)
                r = rresp;
            pr = pr && !rvalid;
            arvalid <= pa;
            rready <= pr;
        end
        if (n >= 100)
            check(32'(n), 32'h0);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        check(d & m, e);
    endtask

    // Model lag plus result register plus flag register, with margin
    task automatic settle;
        repeat (4) @(posedge clock);
    endtask

    task automatic lvl(input logic [7:0] p);
        @(posedge clock);
        pos_lvl[0] <= p;
        settle;
    endtask

    function automatic logic [5:0] onehot(input logic en, input int code, input int lim);
        return (en && code < lim) ? 6'(1 << code) : 6'h00;
    endfunction

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        int ps, ns;
        logic en;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        rd_chk(OFF_CTRL0, 32'hff, 32'h0);
        check(32'(pos_route), 32'h0);
        check(32'(irq), 32'h0);
        axi_rd(8'h20, rd, rs);
        check(32'(rs), 32'(RESP_SLVERR));
        axi_wr(8'h24, 32'h1, rs);
        check(32'(rs), 32'(RESP_SLVERR));
        $display("test reset done");
        // Every source code first, then random codes (unused too) and enable
        for (int k = 0; k < 16; k++)
        begin
            ps = (k < 6) ? k % 5 : int'($unsigned($random(seed)) % 8);
            ns = (k < 6) ? k : int'($unsigned($random(seed)) % 8);
            en = (k < 6) ? 1'b1 : 1'($random(seed));
            wr(OFF_PSEL, 32'(ps));
            wr(OFF_NSEL, 32'(ns));
            wr(OFF_CTRL0, {24'h0, en, 7'h0});
            settle;
            check(32'(pos_route), 32'(onehot(en, ps, 5)));
            check(32'(neg_route), 32'(onehot(en, ns, 6)));
        end
        $display("test routing done");
        wr(OFF_CTRL0, 32'h82);
        settle;
        check(32'(hyst_on), 32'h1);
        wr(OFF_CTRL0, 32'h80);
        settle;
        check(32'(hyst_on), 32'h0);
        $display("test hysteresis done");
        // Software side sets interrupt, global and rising edge enables; falling edge enable comes on last, with rising off
        wr(OFF_PSEL, 32'h0);
        wr(OFF_NSEL, 32'h0);
        wr(OFF_IRQ_ENABLE, 32'h1);
        wr(OFF_INT_CTRL0, 32'h80);
        wr(OFF_CTRL1, 32'h2);
        lvl(8'h20);
        wr(OFF_IRQ_CLEAR, 32'h1);
        settle;
        rd_chk(OFF_IRQ_STATUS, 32'h1, 32'h0);
        lvl(8'hc0);
        rd_chk(OFF_CTRL0, 32'h40, 32'h40);
        rd_chk(OFF_IRQ_STATUS, 32'h1, 32'h1);
        check(32'(irq), 32'h1);
        repeat (20) @(posedge clock);
        rd_chk(OFF_IRQ_STATUS, 32'h1, 32'h1);
        wr(OFF_INT_CTRL0, 32'h0);
        settle;
        check(32'(irq), 32'h0);
        wr(OFF_IRQ_CLEAR, 32'h1);
        settle;
        rd_chk(OFF_IRQ_STATUS, 32'h1, 32'h0);
        lvl(8'h20);
        rd_chk(OFF_IRQ_STATUS, 32'h1, 32'h0);
        wr(OFF_CTRL1, 32'h1);
        lvl(8'hc0);
        rd_chk(OFF_IRQ_STATUS, 32'h1, 32'h0);
        lvl(8'h20);
        rd_chk(OFF_IRQ_STATUS, 32'h1, 32'h1);
        $display("test edges done");
        // Polarity change on a disabled comparator still makes an edge
        wr(OFF_CTRL1, 32'h3);
        wr(OFF_CTRL0, 32'h0);
        wr(OFF_IRQ_CLEAR, 32'h1);
        settle;
        wr(OFF_CTRL0, 32'h10);
        settle;
        rd_chk(OFF_CTRL0, 32'h40, 32'h40);
        rd_chk(OFF_IRQ_STATUS, 32'h1, 32'h1);
        $display("test invert done");
        // Edges every cycle, so the clear collides with a set; a lost set shows on IRQ
        wr(OFF_INT_CTRL0, 32'h80);
        wr(OFF_CTRL0, 32'h80);
        fork
            for (int c = 0; c < 60; c++)
            begin
                @(posedge clock);
                pos_lvl[0] <= c[0] ? 8'hc0 : 8'h20;
            end
            begin
                repeat (10) @(posedge clock);
                wr(OFF_IRQ_CLEAR, 32'h1);
                rd_chk(OFF_IRQ_STATUS, 32'h1, 32'h1);
            end
            begin
                repeat (5) @(posedge clock);
                repeat (40)
                begin
                    @(posedge clock);
                    check(32'(irq), 32'h1);
                end
            end
        join
        $display("test collision done");
        lvl(8'h20);
        wr(OFF_CTRL0, 32'h81);
        lvl(8'hc0);
        rd_chk(OFF_CTRL0, 32'h40, 32'h00);
        tmr_run <= 1'b1;
        repeat (20) @(posedge clock);
        tmr_run <= 1'b0;
        rd_chk(OFF_CTRL0, 32'h40, 32'h40);
        $display("test alignment done");
        give_verdict;
    end

    // Whole run needs about 550 cycles; this bound cuts a hang
    initial
    begin
        repeat (30000) @(posedge clock);
        check(32'h0, 32'h1);
        give_verdict;
    end
endmodule // comparator_edge_irq_control_bench
`default_nettype wire
